/* src/adcs_sequencer.v */
// Control logic of the 8-bit successive-approximation converter with an AXI4-Lite register port.
`timescale 1ns/1ps
//
// Overview of operation
// - At each conversion end, set done flag and load the 8-bit result.
// - The converter raises irq_o at conversion end only while the interrupt mask is set; otherwise software polls the done flag.
// - A conversion lasts 64 clocks, the first part sampling the selected input.
// - After power-on and settling delay, the selected input converts back to back.
// - Any control/status write with byte lane 0 strobed aborts, clears done and restarts with new settings.
// - Reading the result register clears the done flag.
// - Done flag is bit 7 of control/status; 1 means a result is ready.
// - Bit 5 is the software power-on control; 0 off, 1 on.
// - Bits 2 to 0 select one of eight inputs as a binary index.
// - Bit 4 of control/status always reads zero.
// - Result register is read-only, unsigned 8 bits, reset to zero.
// - Inputs beyond the references saturate at ff or 00 without overflow flag.
// - Result is linear and monotonic in the input voltage.
// - Wait mode has no effect; halt disables and needs settling after wakeup.

`include "adcs_defines.vh"

module adcs_sequencer #(
  parameter integer ADDR_W      = 12,
  parameter integer STAB_CYCLES = `ADCS_STAB_CYCLES
) (
  input  wire              clock_i,
  input  wire              rst_i,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output reg               s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output reg               s_axi_wready_o,
  output reg  [1:0]        s_axi_bresp_o,
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output reg               s_axi_arready_o,
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Converter core and input multiplexer
  output reg  [2:0]        input_select_o,
  output reg               converter_power_on_o,
  output reg               sample_o,
  output reg  [7:0]        trial_code_o,
  input  wire              compare_i,
  // System
  input  wire              halt_i,
  output reg               irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0]                result_register;
  reg                       conversion_done_flag;
  reg  [2:0]                input_select;
  reg                       converter_power_on;
  reg                       irq_status;
  reg                       irq_mask;
  reg  [15:0]               stab_count;
  reg  [5:0]                phase;
  reg  [7:0]                sar;
  reg                       aw_held;
  reg                       w_held;
  reg  [ADDR_W-1:0]         waddr;
  reg  [31:0]               wdata;
  reg  [3:0]                wstrb;

  wire                      do_write;
  wire                      write_ok;
  wire                      read_ok;
  wire [7:0]                widx;
  wire [7:0]                ridx;
  wire                      csr_write;
  wire                      result_read;
  wire                      status_write;
  wire                      mask_write;
  wire                      running;
  wire                      slot_end;
  wire                      conv_end;
  wire [2:0]                bit_k;
  wire [7:0]                csr_value;
  reg  [7:0]                next_sar;
  reg  [31:0]               next_rdata;

  localparam [15:0] STAB_LOAD = STAB_CYCLES[15:0];
  localparam integer SAMPLE_END = `ADCS_SAMPLE_CYCLES - 1;
  localparam integer PHASE_END  = `ADCS_CONV_CYCLES - 1;
  localparam [5:0]  LAST_SAMPLE = SAMPLE_END[5:0];
  localparam [5:0]  LAST_PHASE  = PHASE_END[5:0];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign widx     = waddr[9:2];
  assign ridx     = s_axi_araddr_i[9:2];
  assign write_ok = (waddr[ADDR_W-1:10] == 0) &&
                    (widx == `ADCS_IDX_RESULT || widx == `ADCS_IDX_CSR ||
                     widx == `ADCS_IDX_IRQ_STATUS || widx == `ADCS_IDX_IRQ_MASK);
  assign read_ok  = (s_axi_araddr_i[ADDR_W-1:10] == 0) &&
                    (ridx == `ADCS_IDX_RESULT || ridx == `ADCS_IDX_CSR ||
                     ridx == `ADCS_IDX_IRQ_STATUS || ridx == `ADCS_IDX_IRQ_MASK);

  assign do_write     = aw_held && w_held && !s_axi_bvalid_o;
  assign csr_write    = do_write && write_ok && widx == `ADCS_IDX_CSR && wstrb[0];
  assign status_write = do_write && write_ok && widx == `ADCS_IDX_IRQ_STATUS && wstrb[0];
  assign mask_write   = do_write && write_ok && widx == `ADCS_IDX_IRQ_MASK && wstrb[0];
  assign result_read  = s_axi_arvalid_i && s_axi_arready_o && read_ok &&
                        ridx == `ADCS_IDX_RESULT;

  // Reserved bits 6, 4 and 3 always read zero.
  assign csr_value = {conversion_done_flag, 1'b0, converter_power_on, 1'b0, 1'b0,
                      input_select};

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `ADCS_RESP_OKAY;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      waddr           <= {ADDR_W{1'b0}};
      wdata           <= 32'h0000_0000;
      wstrb           <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held         <= 1'b1;
        waddr           <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held         <= 1'b1;
        wdata          <= s_axi_wdata_i;
        wstrb          <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= write_ok ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    case (ridx)
      `ADCS_IDX_RESULT:     next_rdata[7:0] = result_register;
      `ADCS_IDX_CSR:        next_rdata[7:0] = csr_value;
      `ADCS_IDX_IRQ_STATUS: next_rdata[`ADCS_IRQ_DONE_BIT] = irq_status;
      `ADCS_IDX_IRQ_MASK:   next_rdata[`ADCS_IRQ_DONE_BIT] = irq_mask;
      default:              next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `ADCS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= read_ok ? next_rdata : 32'h0000_0000;
        s_axi_rresp_o   <= read_ok ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      input_select       <= 3'b000;
      converter_power_on <= 1'b0;
      irq_mask           <= `ADCS_IRQ_MASK_RESET;
    end else begin
      if (csr_write) begin
        converter_power_on <= wdata[`ADCS_CSR_POWER_BIT];
        input_select       <= wdata[`ADCS_CSR_SEL_HI:`ADCS_CSR_SEL_LO];
      end
      if (mask_write) begin
        irq_mask <= wdata[`ADCS_IRQ_DONE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Settling counter
  // ----------------------------------------------------------------
  // Reloads while powered off or halted, so both power-on and halt wakeup wait again.
  always @(posedge clock_i) begin
    if (rst_i) begin
      stab_count <= STAB_LOAD;
    end else if (!converter_power_on || halt_i) begin
      stab_count <= STAB_LOAD;
    end else if (stab_count != 16'h0000) begin
      stab_count <= stab_count - 16'h0001;
    end
  end

  assign running = converter_power_on && !halt_i && (stab_count == 16'h0000);

  // ----------------------------------------------------------------
  // Successive approximation sequencer
  // ----------------------------------------------------------------
  // Phases 0..31 sample; each later group of four phases decides one bit, MSB first.
  assign slot_end = running && (phase > LAST_SAMPLE) && (phase[1:0] == 2'b11);
  assign bit_k    = 3'd7 - phase[4:2];
  assign conv_end = slot_end && (phase == LAST_PHASE) && !csr_write;

  // The core reports compare_i high while the input is at or above the trial level.
  always @* begin
    next_sar = sar;
    if (!compare_i) begin
      next_sar[bit_k] = 1'b0;
    end
    if (bit_k != 3'd0) begin
      next_sar[bit_k - 3'd1] = 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      phase <= 6'd0;
      sar   <= 8'h00;
    end else if (!running || csr_write) begin
      phase <= 6'd0;
      sar   <= 8'h00;
    end else begin
      phase <= phase + 6'd1;
      if (phase == LAST_SAMPLE) begin
        sar <= 8'h80;
      end else if (slot_end) begin
        sar <= (phase == LAST_PHASE) ? 8'h00 : next_sar;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result and done flag
  // ----------------------------------------------------------------
  // A completing conversion wins over a result read in the same cycle; a control/status write cancels it.
  always @(posedge clock_i) begin
    if (rst_i) begin
      result_register      <= `ADCS_RESULT_RESET;
      conversion_done_flag <= 1'b0;
      irq_status           <= 1'b0;
    end else begin
      if (conv_end) begin
        result_register      <= next_sar;
        conversion_done_flag <= 1'b1;
      end else if (csr_write || result_read) begin
        conversion_done_flag <= 1'b0;
      end
      if (conv_end) begin
        irq_status <= 1'b1;
      end else if (status_write && wdata[`ADCS_IRQ_DONE_BIT]) begin
        irq_status <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the core
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      input_select_o       <= 3'b000;
      converter_power_on_o <= 1'b0;
      sample_o             <= 1'b0;
      trial_code_o         <= 8'h00;
      irq_o                <= 1'b0;
    end else begin
      input_select_o       <= input_select;
      converter_power_on_o <= converter_power_on && !halt_i;
      sample_o             <= running && !csr_write && (phase < LAST_SAMPLE ||
                              phase == LAST_PHASE);
      trial_code_o         <= sar;
      // Masked off after reset, so the converter stays polled-only unless enabled.
      irq_o                <= irq_status && irq_mask;
    end
  end

endmodule

/* src/adcs_defines.vh */
// Register indices, field positions, reset values and timing counts of the converter block.
`ifndef ADCS_DEFINES_VH
`define ADCS_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADCS_IDX_RESULT      8'h70
`define ADCS_IDX_CSR         8'h71
`define ADCS_IDX_IRQ_STATUS  8'h72
`define ADCS_IDX_IRQ_MASK    8'h73

// ----------------------------------------------------------------
// Control/status fields and reset values
// ----------------------------------------------------------------
`define ADCS_CSR_DONE_BIT    7
`define ADCS_CSR_POWER_BIT   5
`define ADCS_CSR_SEL_HI      2
`define ADCS_CSR_SEL_LO      0
`define ADCS_RESULT_RESET    8'h00
`define ADCS_CSR_RESET       8'h00
`define ADCS_IRQ_DONE_BIT    0
`define ADCS_IRQ_MASK_RESET  1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCS_CLK_PERIOD_NS   10
`define ADCS_STAB_TIME_NS    30000
`define ADCS_STAB_CYCLES     ((`ADCS_STAB_TIME_NS + `ADCS_CLK_PERIOD_NS - 1) / `ADCS_CLK_PERIOD_NS)
`define ADCS_CONV_CYCLES     64
`define ADCS_SAMPLE_CYCLES   32
`define ADCS_BIT_CYCLES      4

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define ADCS_RESP_OKAY       2'b00
`define ADCS_RESP_SLVERR     2'b10

`endif

/* verif/adcs_core_model.sv */
// Behavioural model of the input multiplexer and comparator of the converter core.
`timescale 1ns/1ps
module adcs_core_model (
  input  wire logic [2:0]  select_i,
  input  wire logic        power_i,
  input  wire logic [7:0]  trial_i,
  input  wire logic [71:0] levels_i,
  output logic             compare_o
);
  // Levels of 255 and above stand for inputs at or beyond the upper reference.
  // Each input is a plain level with no pull-up or interrupt path behind it.
  assign compare_o = power_i & (levels_i[select_i*9 +: 9] >= {1'b0, trial_i});
endmodule

/* verif/adcs_sequencer_asserts.sv */
// Port-level checker of the converter sequencer.
`timescale 1ns/1ps
module adcs_sequencer_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        sample_o,
  input wire logic [7:0]  trial_code_o,
  input wire logic        converter_power_on_o,
  input wire logic        halt_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_wr_lat;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##1 !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles late");
  property p_rd_lat;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read response not one cycle late");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response changed before taken");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response changed before taken");
  property p_wr_block;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while one outstanding");
  property p_rd_block;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("read taken while one outstanding");
  property p_halt_off;
    halt_i ##1 halt_i |-> !converter_power_on_o;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("core powered in halt");
  property p_trial;
    disable iff (rst_i || halt_i) $fell(sample_o) && !s_axi_bvalid_o |=> trial_code_o == 8'h80;
  endproperty
  a_trial: assert property (p_trial) else $error("first trial code wrong after sampling");
endmodule
bind adcs_sequencer adcs_sequencer_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .sample_o(sample_o),
  .trial_code_o(trial_code_o), .converter_power_on_o(converter_power_on_o), .halt_i(halt_i));

/* verif/tb.sv */
// Self-checking bench of the converter sequencer.
`timescale 1ns/1ps
module tb;
  typedef struct {logic [2:0] ch; logic [8:0] lv; logic [7:0] ex;} adcs_row_t;
  localparam int STAB = 20;
  localparam logic [11:0] A_RES = 12'h1c0, A_CSR = 12'h1c4, A_ST = 12'h1c8, A_MSK = 12'h1cc;
  logic        clock_i, rst_i, halt_i, awv, wv, br, arv, rr, awrdy, wrdy, bv, arrdy, rv;
  logic        pwr, smp, cmp, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  sel;
  logic [7:0]  trial;
  logic [71:0] lv;
  int          miscompares, tests_run, cyc, i, n;
  adcs_row_t   rows [6] = '{'{3'h0, 9'h000, 8'h00}, '{3'h1, 9'h12c, 8'hff},
    '{3'h2, 9'h080, 8'h80}, '{3'h3, 9'h04d, 8'h4d}, '{3'h7, 9'h0ff, 8'hff}, '{3'h5, 9'h001, 8'h01}};
  adcs_sequencer #(.STAB_CYCLES(STAB)) uut (
    .clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .input_select_o(sel),
    .converter_power_on_o(pwr), .sample_o(smp), .trial_code_o(trial), .compare_i(cmp),
    .halt_i(halt_i), .irq_o(irq));
  adcs_core_model core (.select_i(sel), .power_i(pwr), .trial_i(trial), .levels_i(lv),
    .compare_o(cmp));
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_i);
    awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clock_i);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    br <= 0;
    r = bresp;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clock_i);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clock_i);
      if (arrdy) arv <= 0;
    end while (!rv);
    rr <= 0;
    d = rdat;
    r = rresp;
  endtask
  task wait_done;
    for (int k = 0; k < 400; k++) begin
      rd(A_CSR);
      if (d[7] === 1'b1) break;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    {awv, wv, br, arv, rr, halt_i} = 0;
    awa = 0; ara = 0; wd = 0; lv = 0; rst_i = 1; cyc = 0; miscompares = 0; tests_run = 0;
    repeat (10) @(posedge clock_i);
    rst_i <= 0;
    rd(A_RES); chk("result reset", 32'h0, d);
    rd(A_CSR); chk("csr reset", 32'h0, d);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      lv[rows[i].ch*9 +: 9] <= rows[i].lv;
      wr(A_CSR, {24'h0, 5'h06, rows[i].ch}); chk("csr bresp", 2'b00, r);
      @(negedge clock_i); chk("select", rows[i].ch, sel);
      wait_done; chk("csr done", {24'h0, 5'h14, rows[i].ch}, d);
      rd(A_RES); chk("result", rows[i].ex, d);
      rd(A_CSR); chk("done after read", 1'b0, d[7]);
      $display("row %0d test done", i);
    end
    wait_done;
    wr(A_CSR, 32'h25); rd(A_CSR); chk("done after write", 32'h25, d);
    @(posedge smp); n = 0;
    repeat (64) begin @(negedge clock_i); n += smp; end
    chk("sample cycles", 32'd32, n);
    @(negedge clock_i); chk("next conversion", 1'b1, smp);
    $display("timing test done");
    wr(A_RES, 32'h55); chk("ro bresp", 2'b00, r);
    rd(A_RES); chk("ro result", rows[5].ex, d);
    wr(12'h1d0, 32'h1); chk("unmapped bresp", 2'b10, r);
    rd(12'h1d0); chk("unmapped data", 32'h0, d); chk("unmapped rresp", 2'b10, r);
    $display("access test done");
    wait_done; repeat (2) @(negedge clock_i); chk("irq masked", 1'b0, irq);
    rd(A_ST); chk("irq status", 1'b1, d[0]);
    wr(A_MSK, 32'h1); repeat (2) @(negedge clock_i); chk("irq on", 1'b1, irq);
    wr(A_ST, 32'h1); repeat (2) @(negedge clock_i); chk("irq cleared", 1'b0, irq);
    wr(A_MSK, 32'h0);
    $display("interrupt test done");
    wr(A_CSR, 32'h05); @(negedge clock_i); chk("power off", 1'b0, pwr);
    repeat (150) @(posedge clock_i);
    rd(A_CSR); chk("no done when off", 32'h05, d);
    wr(A_CSR, 32'h25); n = 0;
    while (!smp && n < 500) begin @(negedge clock_i); n++; end
    chk("settle wait", 1'b1, n >= STAB);
    $display("power test done");
    @(posedge clock_i); halt_i <= 1;
    repeat (3) @(negedge clock_i); chk("halt power", 1'b0, pwr);
    @(posedge clock_i); halt_i <= 0;
    wait_done; chk("done after halt", 32'ha5, d);
    $display("halt test done");
    test_done;
  end
endmodule
